/* design/atdc_ctrl.sv */
// threshold detect control: registers, comparison engine, buffer placement, low power
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - positive reference: 00 supply, 01 external
// - bit 5 selects external negative reference
// - index enable: channel slot, else FIFO
// - scan bit steps inputs, else fixed
// - compares run in sleep; interrupt wakes
// - low-power enable returns to sleep after service
// - compare field picks one of four tests
// - write field: discard, store, or legacy
// - storing modes: indexed, FIFO or split FIFO
// - window mode pairs slot with mirrored slot
// - thresholds written only while module disabled
// - single threshold read from channel slot
// - window bounds: channel slot and mirror
// - code 01 greater, code 00 less
// - hit: mode 01 replaces, 10 discards
// - hit flag sticky until software clears
module atdc_ctrl
    import atdc_pkg::*;
#(
    parameter int NCH = 16
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic [atdc_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [atdc_pkg::AXI_DW-1:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [atdc_pkg::AXI_AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [atdc_pkg::AXI_DW-1:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic conv_valid, // converter core result offered
    input wire logic [atdc_pkg::BUF_AW-1:0] conv_chan, // converted channel
    input wire logic [atdc_pkg::RES_W-1:0] conv_data, // converted value
    output logic conv_ready, // result taken when high with valid, unless a bus buffer read starts that cycle
    output logic module_en, // converter module enable
    output logic [1:0] pos_ref_select, // positive reference choice
    output logic neg_ref_select, // external negative reference
    output logic offset_calibration, // offset calibration mode
    output logic sample_a_scan_en, // scan inputs in sample A
    input wire logic cpu_sleep_req, // device entering sleep/idle, async
    output logic low_power, // device held in low power
    output logic irq // level interrupt
);
    localparam int NLOW = BUF_DEPTH - MIRROR_OFS;

    // registers
    logic [7:0] ctrl1_r, ctrl1_nxt;
    logic [7:0] adc_control_two_high_r, ctrl2_nxt;
    logic [4:0] ctrl5l_r, ctrl5l_nxt;
    logic lp_en_r, lp_en_nxt;
    logic [NCH-1:0] hit_r, hit_nxt, mask_r, mask_nxt;

    // bus state
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [AXI_AW-1:0] awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
    logic [AXI_DW-1:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [AXI_DW-1:0] rdata_r, rdata_nxt;
    logic ar_have_r, ar_have_nxt, rd_mem_r, rd_mem_nxt;

    // core state
    atdc_core_st_t st_r, st_nxt;
    logic [BUF_AW-1:0] chan_r, chan_nxt, fifo_ptr_r, fifo_ptr_nxt;
    logic [RES_W-1:0] data_r, data_nxt, lo_r, lo_nxt, hi_r, hi_nxt;
    logic conv_ready_r, conv_ready_nxt;

    // low power state
    logic sleep_s1_r, sleep_s2_r, sleep_d_r, lp_r, lp_nxt, woke_r, woke_nxt, irq_r;

    // memory ports
    logic mem_we, mem_re;
    logic [BUF_AW-1:0] mem_waddr, mem_raddr;
    logic [RES_W-1:0] mem_wdata, mem_rdata;

    atdc_buf_mem #(.W(RES_W), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (
        .clk_sys(clk_sys),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .re(mem_re),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    logic wr_go, wr_buf, rd_buf, core_en, window, hit, store, conv_take, bus_rd_go;
    logic [BUF_AW-1:0] mirror, store_slot, fifo_wrap;
    logic [1:0] cm, wm;

    always_comb begin
        core_en = ctrl1_r[MOD_EN_BIT];
        cm = ctrl5l_r[CM_LSB +: 2];
        wm = ctrl5l_r[WM_LSB +: 2];
        window = cm[1];
        mirror = chan_r + BUF_AW'(MIRROR_OFS);
        wr_go = aw_have_r && w_have_r && !bvalid_r;
        wr_buf = awaddr_r[AXI_AW-1 -: 2] == BUF_REGION;
        rd_buf = araddr_r[AXI_AW-1 -: 2] == BUF_REGION;
        // bus buffer reads take the port only while the engine is idle
        bus_rd_go = ar_have_r && !rvalid_r && !rd_mem_r && rd_buf && st_r == C_IDLE;
        conv_take = conv_valid && conv_ready_r && !bus_rd_go;
        // hit evaluation against the captured thresholds
        unique case (cm)
            CM_LESS: hit = data_r < lo_r;
            CM_GREATER: hit = data_r > lo_r;
            CM_INSIDE: hit = data_r > lo_r && data_r < hi_r;
            CM_OUTSIDE: hit = data_r < lo_r || data_r > hi_r;
        endcase
        // split FIFO keeps conversions in slots 0 to 6, below the mirror offset
        fifo_wrap = ctrl5l_r[SPLIT_BIT] ? BUF_AW'(NLOW - 1) : BUF_AW'(BUF_DEPTH - 1);
        store_slot = adc_control_two_high_r[CHIDX_BIT] ? chan_r : fifo_ptr_r;
        store = st_r == C_EVAL && core_en &&
                (wm == WM_LEGACY || (wm == WM_CMP_STORE && hit));
    end

    // memory port steering; bus writes and engine stores never overlap
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = store_slot;
        mem_wdata = data_r;
        if (store) begin
            mem_we = 1'b1;
        end else if (wr_go && wr_buf && !core_en) begin
            mem_we = 1'b1;
            mem_waddr = awaddr_r[2 +: BUF_AW];
            mem_wdata = wdata_r[RES_W-1:0];
        end
        mem_re = 1'b0;
        mem_raddr = araddr_r[2 +: BUF_AW];
        if (bus_rd_go) begin
            mem_re = 1'b1;
        end else if (conv_take) begin
            mem_re = 1'b1;
            mem_raddr = conv_chan;
        end else if (st_r == C_LO && window) begin
            mem_re = 1'b1;
            mem_raddr = mirror;
        end
    end

    // comparison engine
    always_comb begin
        st_nxt = st_r;
        chan_nxt = chan_r;
        data_nxt = data_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        fifo_ptr_nxt = fifo_ptr_r;
        unique case (st_r)
            C_IDLE: begin
                if (conv_take) begin
                    chan_nxt = conv_chan;
                    data_nxt = conv_data;
                    st_nxt = wm == WM_LEGACY ? C_EVAL : C_LO;
                end
            end
            C_LO: begin
                lo_nxt = mem_rdata;
                st_nxt = window ? C_HI : C_EVAL;
            end
            C_HI: begin
                hi_nxt = mem_rdata;
                st_nxt = C_EVAL;
            end
            C_EVAL: begin
                st_nxt = C_IDLE;
                if (store && !adc_control_two_high_r[CHIDX_BIT]) begin
                    fifo_ptr_nxt = fifo_ptr_r == fifo_wrap ? '0 : fifo_ptr_r + 1'b1;
                end
            end
        endcase
        if (!core_en) begin
            fifo_ptr_nxt = '0;
        end
        // engine keeps running in sleep; only the module enable gates it
        conv_ready_nxt = core_en && st_nxt == C_IDLE;
    end

    // register file and bus slave
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = adc_control_two_high_r;
        ctrl5l_nxt = ctrl5l_r;
        lp_en_nxt = lp_en_r;
        mask_nxt = mask_r;
        hit_nxt = hit_r;
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        ar_have_nxt = ar_have_r;
        araddr_nxt = araddr_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        rd_mem_nxt = 1'b0;
        if (s_axi_awvalid && !aw_have_r) begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_r) begin
            w_have_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if (wr_buf) begin
                if (core_en) begin
                    bresp_nxt = RESP_SLVERR;
                end
            end else if (wstrb_r[0]) begin
                unique case (awaddr_r)
                    OFS_CTRL_ONE_H: ctrl1_nxt[MOD_EN_BIT] = wdata_r[MOD_EN_BIT];
                    OFS_CTRL_TWO_H: ctrl2_nxt = wdata_r[7:0] & CTRL_TWO_H_MASK;
                    OFS_CTRL_FIVE_L: ctrl5l_nxt = wdata_r[4:0];
                    OFS_CTRL_FIVE_H: lp_en_nxt = wdata_r[LP_EN_BIT];
                    OFS_HIT_STAT: hit_nxt = hit_r & ~wdata_r[NCH-1:0];
                    OFS_HIT_MASK: mask_nxt = wdata_r[NCH-1:0];
                    OFS_STATE: ;
                    default: bresp_nxt = RESP_SLVERR;
                endcase
            end
        end
        // set wins over a same-cycle clear
        if (st_r == C_EVAL && wm != WM_LEGACY && hit && NCH'(chan_r) < NCH) begin
            hit_nxt[chan_r] = 1'b1;
        end
        if (s_axi_arvalid && !ar_have_r) begin
            ar_have_nxt = 1'b1;
            araddr_nxt = s_axi_araddr;
        end
        if (rd_mem_r) begin
            rdata_nxt = AXI_DW'(mem_rdata);
            rresp_nxt = RESP_OKAY;
            rvalid_nxt = 1'b1;
            ar_have_nxt = 1'b0;
        end else if (ar_have_r && !rvalid_r && !rd_buf) begin
            rvalid_nxt = 1'b1;
            ar_have_nxt = 1'b0;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = '0;
            unique case (araddr_r)
                OFS_CTRL_ONE_H: rdata_nxt[7:0] = ctrl1_r;
                OFS_CTRL_TWO_H: rdata_nxt[7:0] = adc_control_two_high_r;
                OFS_CTRL_FIVE_L: rdata_nxt[4:0] = ctrl5l_r;
                OFS_CTRL_FIVE_H: rdata_nxt[LP_EN_BIT] = lp_en_r;
                OFS_HIT_STAT: rdata_nxt[NCH-1:0] = hit_r;
                OFS_HIT_MASK: rdata_nxt[NCH-1:0] = mask_r;
                OFS_STATE: rdata_nxt[7:0] = {lp_r, st_r != C_IDLE, 2'h0, fifo_ptr_r};
                default: rresp_nxt = RESP_SLVERR;
            endcase
        end
        if (bus_rd_go) begin
            rd_mem_nxt = 1'b1;
        end
    end

    // low power: wake on interrupt, fall back once it is serviced
    always_comb begin
        lp_nxt = lp_r;
        woke_nxt = woke_r;
        if (lp_r && irq_r) begin
            lp_nxt = 1'b0;
            woke_nxt = 1'b1;
        end else if (woke_r && !irq_r) begin
            lp_nxt = lp_en_r;
            woke_nxt = 1'b0;
        end else if (sleep_s2_r && !sleep_d_r) begin
            lp_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_r <= '0;
            adc_control_two_high_r <= CTRL_TWO_H_RST;
            ctrl5l_r <= '0;
            lp_en_r <= 1'b0;
            hit_r <= '0;
            mask_r <= '0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            ar_have_r <= 1'b0;
            araddr_r <= '0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
            rd_mem_r <= 1'b0;
            st_r <= C_IDLE;
            chan_r <= '0;
            data_r <= '0;
            lo_r <= '0;
            hi_r <= '0;
            fifo_ptr_r <= '0;
            conv_ready_r <= 1'b0;
            sleep_s1_r <= 1'b0;
            sleep_s2_r <= 1'b0;
            sleep_d_r <= 1'b0;
            lp_r <= 1'b0;
            woke_r <= 1'b0;
            irq_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            adc_control_two_high_r <= ctrl2_nxt;
            ctrl5l_r <= ctrl5l_nxt;
            lp_en_r <= lp_en_nxt;
            hit_r <= hit_nxt;
            mask_r <= mask_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            ar_have_r <= ar_have_nxt;
            araddr_r <= araddr_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            rd_mem_r <= rd_mem_nxt;
            st_r <= st_nxt;
            chan_r <= chan_nxt;
            data_r <= data_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            fifo_ptr_r <= fifo_ptr_nxt;
            conv_ready_r <= conv_ready_nxt;
            sleep_s1_r <= cpu_sleep_req;
            sleep_s2_r <= sleep_s1_r;
            sleep_d_r <= sleep_s2_r;
            lp_r <= lp_nxt;
            woke_r <= woke_nxt;
            irq_r <= |(hit_nxt & mask_nxt);
            s_axi_awready <= !aw_have_nxt;
            s_axi_wready <= !w_have_nxt;
            s_axi_arready <= !ar_have_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign conv_ready = conv_ready_r;
    assign module_en = ctrl1_r[MOD_EN_BIT];
    assign pos_ref_select = adc_control_two_high_r[POS_REF_LSB +: 2];
    assign neg_ref_select = adc_control_two_high_r[NEG_REF_BIT];
    assign offset_calibration = adc_control_two_high_r[OFFSET_CALIBRATION_BIT];
    assign sample_a_scan_en = adc_control_two_high_r[SCAN_BIT];
    assign low_power = lp_r;
    assign irq = irq_r;
endmodule : atdc_ctrl

/* design/atdc_pkg.sv */
// constants, register map and encodings for the converter threshold detect control
package atdc_pkg;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
    localparam int RES_W = 12;
    localparam int MIRROR_OFS = 9;

    localparam logic [AXI_AW-1:0] OFS_CTRL_ONE_H = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_CTRL_TWO_H = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_CTRL_FIVE_L = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_CTRL_FIVE_H = 8'h0c;
    localparam logic [AXI_AW-1:0] OFS_HIT_STAT = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_HIT_MASK = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_STATE = 8'h18;
    localparam logic [1:0] BUF_REGION = 2'h1;

    localparam int MOD_EN_BIT = 7;
    localparam int POS_REF_LSB = 6;
    localparam int NEG_REF_BIT = 5;
    localparam int OFFSET_CALIBRATION_BIT = 4;
    localparam int CHIDX_BIT = 3;
    localparam int SCAN_BIT = 2;
    localparam int CM_LSB = 0;
    localparam int WM_LSB = 2;
    localparam int SPLIT_BIT = 4;
    localparam int LP_EN_BIT = 6;

    localparam logic [7:0] CTRL_TWO_H_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_H_MASK = 8'hfc;

    localparam logic [1:0] POS_REF_ANALOG_SUPPLY = 2'h0;
    localparam logic [1:0] POS_REF_EXTERNAL = 2'h1;

    localparam logic [1:0] CM_LESS = 2'h0;
    localparam logic [1:0] CM_GREATER = 2'h1;
    localparam logic [1:0] CM_INSIDE = 2'h2;
    localparam logic [1:0] CM_OUTSIDE = 2'h3;

    localparam logic [1:0] WM_LEGACY = 2'h0;
    localparam logic [1:0] WM_CMP_STORE = 2'h1;
    localparam logic [1:0] WM_CMP_DISCARD = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {C_IDLE, C_LO, C_HI, C_EVAL} atdc_core_st_t;
endpackage : atdc_pkg

/* design/atdc_buf_mem.sv */
// results buffer: one write port, one read port with registered read data
`timescale 1ns/1ps
module atdc_buf_mem #(
    parameter int W = 12,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_sys, // system clock
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write slot
    input wire logic [W-1:0] wdata, // write value
    input wire logic re, // read strobe
    input wire logic [AW-1:0] raddr, // read slot
    output logic [W-1:0] rdata // read value, one cycle after re
);
    logic [W-1:0] mem [DEPTH];

    // no reset on storage: thresholds are always loaded by software first
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule : atdc_buf_mem

/* bench/atdc_ctrl_sva.sv */
// bus, converter-port and wake checks on the threshold detect control ports
`timescale 1ns/1ps
module atdc_ctrl_sva #(
    parameter int NCH = 16
) (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset, low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic conv_valid, // result offered
    input wire logic conv_ready, // result taken
    input wire logic cpu_sleep_req, // sleep request
    input wire logic low_power, // low power state
    input wire logic irq // interrupt
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_take |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
    property p_rd_answer;
        s_rd_take |-> ##[2:8] s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read response missing");
    property p_aw_block;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("address taken twice");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");
    property p_conv_drop;
        conv_valid && conv_ready |=> !conv_ready;
    endproperty
    a_conv_drop: assert property (p_conv_drop) else $error("ready held while busy");
    // flags clear only by a bus write, so irq falls as its response rises
    property p_irq_sticky;
        $fell(irq) |-> s_axi_bvalid;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell without write");
    property p_wake;
        low_power && irq |-> ##[1:2] !low_power;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not wake");
    property p_sleep;
        $rose(cpu_sleep_req) && !irq |-> ##[1:5] low_power;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep request ignored");
endmodule : atdc_ctrl_sva

bind atdc_ctrl atdc_ctrl_sva #(.NCH(NCH)) u_sva (.clk_sys, .rst_n, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .conv_valid,
    .conv_ready, .cpu_sleep_req, .low_power, .irq);

/* bench/atdc_core_model.sv */
// converter core stand-in: offers one result and holds it until taken
`timescale 1ns/1ps
module atdc_core_model
    import atdc_pkg::*;
(
    input wire logic clk_sys, // system clock
    output logic conv_valid, // result offered
    output logic [atdc_pkg::BUF_AW-1:0] conv_chan, // channel
    output logic [atdc_pkg::RES_W-1:0] conv_data, // value
    input wire logic conv_ready // taken with valid
);
    initial begin
        conv_valid = 1'b0;
        conv_chan = '0;
        conv_data = '0;
    end
    // gap makes a slow core; payload scrambled outside an offer
    task automatic send(input logic [3:0] c, input logic [11:0] d, input int gap);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        conv_valid <= 1'b1;
        conv_chan <= c;
        conv_data <= d;
        do @(posedge clk_sys); while (conv_ready !== 1'b1);
        conv_valid <= 1'b0;
        conv_chan <= ~c;
        conv_data <= ~d;
    endtask : send
endmodule : atdc_core_model

/* bench/tb_top.sv */
// self-checking bench for the threshold detect control
`timescale 1ns/1ps
module tb_top;
    import atdc_pkg::*;
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, conv_valid, conv_ready, module_en, neg_ref_select;
    logic offset_calibration, sample_a_scan_en, cpu_sleep_req, low_power, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, conv_chan;
    logic [1:0] s_axi_bresp, s_axi_rresp, pos_ref_select;
    logic [11:0] conv_data;
    int err_total = 0;
    int n_compared = 0;
    atdc_ctrl dut (.*);
    atdc_core_model u_core (.clk_sys, .conv_valid, .conv_chan, .conv_data, .conv_ready);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
        if (er == RESP_OKAY) chk(s_axi_rdata, e);
    endtask : rd
    function automatic logic [7:0] slot(input int s);
        return {BUF_REGION, s[3:0], 2'b00};
    endfunction : slot
    task automatic t_regs;
        rd(OFS_CTRL_TWO_H, 32'h0, RESP_OKAY);
        wr(OFS_CTRL_TWO_H, 32'h7f, RESP_OKAY);
        rd(OFS_CTRL_TWO_H, 32'h7c, RESP_OKAY);
        chk(pos_ref_select, POS_REF_EXTERNAL);
        chk(neg_ref_select, 1'b1);
        chk(sample_a_scan_en, 1'b1);
        chk(offset_calibration, 1'b1);
        wr(OFS_CTRL_TWO_H, 32'h08, RESP_OKAY);
        chk(pos_ref_select, POS_REF_ANALOG_SUPPLY);
        chk({neg_ref_select, sample_a_scan_en}, 2'h0);
        rd(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h34, 32'hff, RESP_SLVERR);
        wr(OFS_CTRL_ONE_H, 32'h80, RESP_OKAY);
        chk(module_en, 1'b1);
    endtask : t_regs
    // one conversion against thresholds loaded while the module is off
    task automatic t_compare(input logic [1:0] cm, input logic [1:0] wm, input int ch,
                             input logic [11:0] lo, input logic [11:0] hi,
                             input logic [11:0] x, input logic hit);
        logic [11:0] e;
        e = ((wm == WM_CMP_STORE && hit) || wm == WM_LEGACY) ? x : lo;
        wr(OFS_CTRL_ONE_H, 32'h0, RESP_OKAY);
        wr(OFS_CTRL_TWO_H, 32'h08, RESP_OKAY);
        wr(slot(ch), {20'h0, lo}, RESP_OKAY);
        wr(slot((ch + MIRROR_OFS) % 16), {20'h0, hi}, RESP_OKAY);
        wr(OFS_CTRL_FIVE_L, {28'h0, wm, cm}, RESP_OKAY);
        wr(OFS_HIT_STAT, 32'hffff, RESP_OKAY);
        wr(OFS_HIT_MASK, 32'hffff, RESP_OKAY);
        wr(OFS_CTRL_ONE_H, 32'h80, RESP_OKAY);
        wr(slot(ch), 32'h0, RESP_SLVERR);
        u_core.send(ch[3:0], x, 0);
        repeat (4) @(posedge clk_sys);
        rd(OFS_HIT_STAT, {31'h0, hit} << ch, RESP_OKAY);
        chk(irq, hit);
        wr(OFS_CTRL_ONE_H, 32'h0, RESP_OKAY);
        rd(slot(ch), {20'h0, e}, RESP_OKAY);
    endtask : t_compare
    task automatic t_modes;
        t_compare(CM_GREATER, WM_CMP_STORE, 3, 12'h100, 12'h0, 12'h180, 1'b1);
        t_compare(CM_GREATER, WM_CMP_STORE, 3, 12'h100, 12'h0, 12'h0ff, 1'b0);
        t_compare(CM_LESS, WM_CMP_DISCARD, 2, 12'h100, 12'h0, 12'h050, 1'b1);
        t_compare(CM_LESS, WM_CMP_DISCARD, 2, 12'h100, 12'h0, 12'h100, 1'b0);
        t_compare(CM_INSIDE, WM_CMP_DISCARD, 0, 12'h100, 12'h200, 12'h150, 1'b1);
        t_compare(CM_INSIDE, WM_CMP_DISCARD, 0, 12'h100, 12'h200, 12'h200, 1'b0);
        t_compare(CM_OUTSIDE, WM_CMP_DISCARD, 6, 12'h100, 12'h200, 12'h201, 1'b1);
        t_compare(CM_OUTSIDE, 2'h3, 6, 12'h100, 12'h200, 12'h150, 1'b0);
        t_compare(CM_LESS, WM_LEGACY, 5, 12'h100, 12'h0, 12'h050, 1'b0);
    endtask : t_modes
    task automatic t_fifo;
        wr(OFS_CTRL_ONE_H, 32'h0, RESP_OKAY);
        wr(OFS_CTRL_TWO_H, 32'h0, RESP_OKAY);
        wr(OFS_CTRL_FIVE_L, 32'h10, RESP_OKAY);
        wr(OFS_CTRL_ONE_H, 32'h80, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            u_core.send(4'h5, 12'h0a0 + 12'(i), i % 3);
        end
        repeat (4) @(posedge clk_sys);
        wr(OFS_CTRL_ONE_H, 32'h0, RESP_OKAY);
        for (int i = 0; i < 7; i++) begin
            rd(slot(i), i ? 32'ha0 + i : 32'ha7, RESP_OKAY);
        end
    endtask : t_fifo
    task automatic t_lowpower;
        wr(OFS_CTRL_TWO_H, 32'h08, RESP_OKAY);
        wr(slot(1), 32'h0, RESP_OKAY);
        wr(OFS_CTRL_FIVE_L, 32'h09, RESP_OKAY);
        wr(OFS_HIT_STAT, 32'hffff, RESP_OKAY);
        wr(OFS_HIT_MASK, 32'h0, RESP_OKAY);
        wr(OFS_CTRL_FIVE_H, 32'h40, RESP_OKAY);
        wr(OFS_CTRL_ONE_H, 32'h80, RESP_OKAY);
        cpu_sleep_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(low_power, 1'b1);
        u_core.send(4'h1, 12'h005, 0);
        repeat (4) @(posedge clk_sys);
        chk({irq, low_power}, 2'h1);
        wr(OFS_HIT_MASK, 32'h2, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        chk({irq, low_power}, 2'h2);
        wr(OFS_HIT_STAT, 32'h2, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        chk({irq, low_power}, 2'h1);
        wr(OFS_CTRL_FIVE_H, 32'h0, RESP_OKAY);
        u_core.send(4'h1, 12'h007, 0);
        repeat (4) @(posedge clk_sys);
        chk({irq, low_power}, 2'h2);
        wr(OFS_HIT_STAT, 32'h2, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        chk({irq, low_power}, 2'h0);
    endtask : t_lowpower
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        cpu_sleep_req = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_modes();
        t_fifo();
        t_lowpower();
        stop_test();
    end
    // run takes several hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        stop_test();
    end
endmodule : tb_top
